// [hw/cpu_mac_decoder.sv]
// Behaviour
// (RQ1) Add/sub word/byte, carry, 2 or 4 bytes
// (RQ2) Signed/unsigned 16x16 register multiply, 2 bytes
// (RQ3) Divide low word or long pair
// (RQ4) Bit set/clear 2 bytes, bit logic 4
// (RQ5) Masked high/low byte field modify, 4 bytes
// (RQ6) Compare and decrement register by 1/2
// (RQ7) Compare and increment register by 1/2
// (RQ8) Normalisation count into another register, 2 bytes
// (RQ9) Arithmetic right shift with sign fill
// (RQ10) Byte-to-word move, sign or zero extend
// (RQ11) Jump if bit set, clear it
// (RQ12) Jump if bit clear, set it
// (RQ13) Push register then call absolute, 4 bytes
// (RQ14) Push register then load it, 4 bytes
// (RQ15) Return and pop register, 2 bytes
// (RQ16) Software trap via immediate number, 2 bytes
// (RQ17) Power down only with interrupt pin low
// (RQ18) End of init shown on reset pin
// (RQ19) Every co-processor instruction is 4 bytes
// (RQ20) Multiply-accumulate, operand signedness, rounding, move
// (RQ21) Accumulator arithmetic shift right, optional round
// (RQ22) Extended page/segment prefixes, 2 or 4
// (RQ23) Branch 2, multiply 5, divide 10 cycles
// (RQ24) Register operands within context pointer bank
// (RQ25) Report length 2 or 4 to fetch
`timescale 1ns/1ps
`default_nettype none
module cpu_mac_decoder import isa_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [15:0] fetchWord,
	input wire logic fetchValid,
	output logic fetchReady,
	input wire logic [15:0] contextPointer,
	input wire logic nmiPin,
	output logic decValid,
	output logic [2:0] lengthBytes,
	output op_t baseOp,
	output logic [1:0] variant,
	output logic illegal,
	output logic [15:0] regAddrA,
	output logic [15:0] regAddrB,
	output logic [15:0] immWord,
	output logic [6:0] trapNumber,
	output logic signed [2:0] regStep,
	output logic jumpClearBit,
	output logic jumpSetBit,
	output logic stackPush,
	output logic stackPop,
	output logic isCoproc,
	output coop_t coprocOp,
	output logic coprocRound,
	output logic coprocUnsA,
	output logic coprocUnsB,
	output logic coprocMove,
	output logic powerDown,
	output logic resetOutActive
);
	dec_if decBus();

	op_classifier uClass (
		.dec(decBus)
	);

	exec_timer uTimer (
		.clk(clk),
		.arst_n(arst_n),
		.dec(decBus)
	);

	state_t state;
	state_t next_state;
	logic [15:0] firstWord;
	logic [15:0] next_firstWord;
	logic next_fetchReady;
	logic nmiMeta;
	logic nmiSync;
	logic next_nmiMeta;
	logic next_nmiSync;
	logic next_decValid;
	logic [2:0] next_lengthBytes;
	op_t next_baseOp;
	logic [1:0] next_variant;
	logic next_illegal;
	logic [15:0] next_regAddrA;
	logic [15:0] next_regAddrB;
	logic [15:0] next_immWord;
	logic [6:0] next_trapNumber;
	logic signed [2:0] next_regStep;
	logic next_jumpClearBit;
	logic next_jumpSetBit;
	logic next_stackPush;
	logic next_stackPop;
	logic next_isCoproc;
	coop_t next_coprocOp;
	logic next_coprocRound;
	logic next_coprocUnsA;
	logic next_coprocUnsB;
	logic next_coprocMove;
	logic next_powerDown;
	logic next_resetOutActive;

	logic accept;
	logic complete;
	logic issue;
	logic [15:0] headWord;
	logic [15:0] longWord;
	op_t op;

	// Word steering and classifier feed
	always_comb begin
		accept = fetchValid && fetchReady;
		headWord = (state == ST_FIRST) ? fetchWord : firstWord;
		longWord = (state == ST_SECOND) ? fetchWord : WORD_ZERO;
		decBus.opcode = headWord[W_OPC_HI:W_OPC_LO];
		op = decBus.baseOp;
		complete = accept && ((state == ST_FIRST && !decBus.len4) || state == ST_SECOND); // see (RQ25)
		issue = complete && decBus.legal;
		decBus.start = issue && (decBus.cycles != CYC_SINGLE); // see (RQ23)
	end

	// Sequencing and decode fields
	always_comb begin
		next_state = state;
		next_firstWord = firstWord;
		next_nmiMeta = nmiPin;
		next_nmiSync = nmiMeta;
		unique case (state)
			ST_FIRST: begin
				if (accept && decBus.len4) begin
					next_state = ST_SECOND; // see (RQ25)
					next_firstWord = fetchWord;
				end else if (accept && decBus.start) begin
					next_state = ST_BUSY;
				end
			end
			ST_SECOND: begin
				if (accept) begin
					next_state = decBus.start ? ST_BUSY : ST_FIRST;
				end
			end
			ST_BUSY: begin
				if (decBus.count == CNT_ONE) begin
					next_state = ST_FIRST; // see (RQ23)
				end
			end
			default: begin
				next_state = ST_FIRST;
			end
		endcase
		next_fetchReady = (next_state != ST_BUSY);

		next_decValid = complete;
		next_lengthBytes = lengthBytes;
		next_baseOp = baseOp;
		next_variant = variant;
		next_illegal = illegal;
		next_regAddrA = regAddrA;
		next_regAddrB = regAddrB;
		next_immWord = immWord;
		next_trapNumber = trapNumber;
		next_regStep = regStep;
		next_jumpClearBit = jumpClearBit;
		next_jumpSetBit = jumpSetBit;
		next_stackPush = stackPush;
		next_stackPop = stackPop;
		next_isCoproc = isCoproc;
		next_coprocOp = coprocOp;
		next_coprocRound = coprocRound;
		next_coprocUnsA = coprocUnsA;
		next_coprocUnsB = coprocUnsB;
		next_coprocMove = coprocMove;
		next_powerDown = powerDown;
		next_resetOutActive = resetOutActive;

		if (complete) begin
			// Operation class with its width, carry, sign and form variants
			next_lengthBytes = decBus.len4 ? LEN_BYTES_4 : LEN_BYTES_2; // see (RQ1) see (RQ10)
			next_baseOp = op; // see (RQ2) see (RQ3) see (RQ4) see (RQ5) see (RQ8) see (RQ9)
			next_variant = decBus.variant; // see (RQ22)
			next_illegal = !decBus.legal;
			next_regAddrA = gpr_addr(contextPointer, headWord[W_RA_HI:W_RA_LO]); // see (RQ24)
			next_regAddrB = gpr_addr(contextPointer, headWord[W_RB_HI:W_RB_LO]); // see (RQ24)
			next_immWord = longWord;
			next_trapNumber = (issue && op == OP_TRAP) ? headWord[W_TRAP_HI:W_TRAP_LO]
				: TRAP_ZERO; // see (RQ16)
			next_regStep = STEP_NONE;
			if (issue && op == OP_CMPD) begin
				next_regStep = decBus.variant[VAR_STEP2] ? STEP_MINUS2 : STEP_MINUS1; // see (RQ6)
			end else if (issue && op == OP_CMPI) begin
				next_regStep = decBus.variant[VAR_STEP2] ? STEP_PLUS2 : STEP_PLUS1; // see (RQ7)
			end
			next_jumpClearBit = issue && op == OP_JBIT && decBus.variant == V_JBC; // see (RQ11)
			next_jumpSetBit = issue && op == OP_JBIT && decBus.variant == V_JUMP_AND_SET_BIT; // see (RQ12)
			next_stackPush = issue && (op == OP_PUSH_AND_CALL || op == OP_CONTEXT_SWITCH_PUSH_LOAD ||
				(op == OP_PUSHPOP && !decBus.variant[VAR_POP])); // see (RQ13) see (RQ14)
			next_stackPop = issue && ((op == OP_RET && decBus.variant == V_RETURN_AND_POP) ||
				(op == OP_PUSHPOP && decBus.variant[VAR_POP])); // see (RQ15)
			next_isCoproc = issue && op == OP_COPROC; // see (RQ19)
			next_coprocOp = next_isCoproc ? coop_t'(headWord[W_CO_OP_HI:W_CO_OP_LO]) : CO_NOP;
			next_coprocRound = next_isCoproc && headWord[W_CO_RND]; // see (RQ20) see (RQ21)
			next_coprocUnsA = next_isCoproc && headWord[W_CO_UA]; // see (RQ20)
			next_coprocUnsB = next_isCoproc && headWord[W_CO_UB]; // see (RQ20)
			next_coprocMove = next_isCoproc && next_coprocOp == CO_MACM; // see (RQ20)
			if (issue && op == OP_SYS && decBus.variant == V_POWER_DOWN_ENTRY && !nmiSync) begin
				next_powerDown = 1'b1; // see (RQ17)
			end
			if (issue && op == OP_SYS && decBus.variant == V_END_OF_INIT) begin
				next_resetOutActive = 1'b0; // see (RQ18)
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_FIRST;
			firstWord <= WORD_ZERO;
			fetchReady <= 1'b1;
			nmiMeta <= 1'b0;
			nmiSync <= 1'b0;
			decValid <= 1'b0;
			lengthBytes <= LEN_BYTES_2;
			baseOp <= OP_NOP;
			variant <= VAR_ZERO;
			illegal <= 1'b0;
			regAddrA <= WORD_ZERO;
			regAddrB <= WORD_ZERO;
			immWord <= WORD_ZERO;
			trapNumber <= TRAP_ZERO;
			regStep <= STEP_NONE;
			jumpClearBit <= 1'b0;
			jumpSetBit <= 1'b0;
			stackPush <= 1'b0;
			stackPop <= 1'b0;
			isCoproc <= 1'b0;
			coprocOp <= CO_NOP;
			coprocRound <= 1'b0;
			coprocUnsA <= 1'b0;
			coprocUnsB <= 1'b0;
			coprocMove <= 1'b0;
			powerDown <= 1'b0;
			resetOutActive <= 1'b1;
		end else begin
			state <= next_state;
			firstWord <= next_firstWord;
			fetchReady <= next_fetchReady;
			nmiMeta <= next_nmiMeta;
			nmiSync <= next_nmiSync;
			decValid <= next_decValid;
			lengthBytes <= next_lengthBytes;
			baseOp <= next_baseOp;
			variant <= next_variant;
			illegal <= next_illegal;
			regAddrA <= next_regAddrA;
			regAddrB <= next_regAddrB;
			immWord <= next_immWord;
			trapNumber <= next_trapNumber;
			regStep <= next_regStep;
			jumpClearBit <= next_jumpClearBit;
			jumpSetBit <= next_jumpSetBit;
			stackPush <= next_stackPush;
			stackPop <= next_stackPop;
			isCoproc <= next_isCoproc;
			coprocOp <= next_coprocOp;
			coprocRound <= next_coprocRound;
			coprocUnsA <= next_coprocUnsA;
			coprocUnsB <= next_coprocUnsB;
			coprocMove <= next_coprocMove;
			powerDown <= next_powerDown;
			resetOutActive <= next_resetOutActive;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_stall_mul;
		!fetchReady [*4] ##1 fetchReady;
	endsequence

	sequence s_stall_div;
		!fetchReady [*8] ##1 !fetchReady ##1 fetchReady;
	endsequence

	property p_long_length;
		(state == ST_SECOND && fetchValid && fetchReady) |=> decValid && lengthBytes == LEN_BYTES_4;
	endproperty
	a_long_length: // see (RQ25)
	assert property (p_long_length) else $error("Second word did not give a 4-byte decode");

	property p_coproc_long;
		(decValid && isCoproc) |-> lengthBytes == LEN_BYTES_4;
	endproperty
	a_coproc_long: // see (RQ19)
	assert property (p_coproc_long) else $error("Co-processor decode not 4 bytes");

	property p_mul_time;
		(decValid && !illegal && baseOp == OP_MUL) |-> s_stall_mul;
	endproperty
	a_mul_time: // see (RQ23)
	assert property (p_mul_time) else $error("Multiply did not occupy 5 cycles");

	property p_div_time;
		(decValid && !illegal && baseOp == OP_DIV) |-> s_stall_div;
	endproperty
	a_div_time: // see (RQ23)
	assert property (p_div_time) else $error("Divide did not occupy 10 cycles");

	property p_branch_time;
		(decValid && !illegal && op_is_branch(baseOp)) |-> !fetchReady ##1 fetchReady;
	endproperty
	a_branch_time: // see (RQ23)
	assert property (p_branch_time) else $error("Branch did not occupy 2 cycles");

	property p_power_down_entry_nmi;
		$rose(powerDown) |-> !$past(nmiSync);
	endproperty
	a_power_down_entry_nmi: // see (RQ17)
	assert property (p_power_down_entry_nmi) else $error("Power down entered with interrupt pin high");

	property p_end_of_init_pin;
		$fell(resetOutActive) |->
			decValid && !illegal && baseOp == OP_SYS && variant == V_END_OF_INIT;
	endproperty
	a_end_of_init_pin: // see (RQ18)
	assert property (p_end_of_init_pin) else $error("Reset output released without end of init");

	property p_cmpd_step;
		(decValid && !illegal && baseOp == OP_CMPD) |->
			regStep == (variant[VAR_STEP2] ? STEP_MINUS2 : STEP_MINUS1);
	endproperty
	a_cmpd_step: // see (RQ6)
	assert property (p_cmpd_step) else $error("Compare-decrement step wrong");

	property p_cmpi_step;
		(decValid && !illegal && baseOp == OP_CMPI) |->
			regStep == (variant[VAR_STEP2] ? STEP_PLUS2 : STEP_PLUS1);
	endproperty
	a_cmpi_step: // see (RQ7)
	assert property (p_cmpi_step) else $error("Compare-increment step wrong");

	property p_jbc_clear;
		(decValid && !illegal && baseOp == OP_JBIT && variant == V_JBC) |->
			jumpClearBit && !jumpSetBit;
	endproperty
	a_jbc_clear: // see (RQ11)
	assert property (p_jbc_clear) else $error("Jump-and-clear did not flag bit clear");

	property p_jump_and_set_bit_set;
		(decValid && !illegal && baseOp == OP_JBIT && variant == V_JUMP_AND_SET_BIT) |->
			jumpSetBit && !jumpClearBit;
	endproperty
	a_jump_and_set_bit_set: // see (RQ12)
	assert property (p_jump_and_set_bit_set) else $error("Jump-and-set did not flag bit set");

endmodule : cpu_mac_decoder
`default_nettype wire

// [hw/dec_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dec_if import isa_pkg::*; ();
	logic [7:0] opcode;
	op_t baseOp;
	logic [1:0] variant;
	logic legal;
	logic len4;
	logic [3:0] cycles;
	logic start;
	logic [3:0] count;

	modport core (output opcode, output start, input baseOp, input variant, input legal,
		input len4, input cycles, input count);
	modport classify (input opcode, output baseOp, output variant, output legal, output len4,
		output cycles);
	modport timer (input start, input cycles, output count);
endinterface : dec_if
`default_nettype wire

// [hw/exec_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module exec_timer import isa_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	dec_if.timer dec
);
	logic [3:0] count;
	logic [3:0] next_count;

	always_comb begin
		next_count = count;
		if (dec.start) begin
			next_count = dec.cycles - CYC_SINGLE; // see (RQ23)
		end else if (count != CNT_ZERO) begin
			next_count = count - CNT_ONE;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= CNT_ZERO;
		end else begin
			count <= next_count;
		end
	end

	assign dec.count = count;

	property p_count_down;
		@(posedge clk) disable iff (!arst_n)
		(count != CNT_ZERO && !dec.start) |=> (count == $past(count) - CNT_ONE);
	endproperty
	a_count_down: // see (RQ23)
	assert property (p_count_down) else $error("Execution counter failed to step down");

endmodule : exec_timer
`default_nettype wire

// [hw/isa_pkg.sv]
package isa_pkg;

	// Opcode byte layout: base operation, variant pair, long-form bit
	localparam int OPC_BASE_HI = 7;
	localparam int OPC_BASE_LO = 3;
	localparam int OPC_VAR_HI = 2;
	localparam int OPC_VAR_LO = 1;
	localparam int OPC_LONG = 0;

	// First instruction word layout
	localparam int W_OPC_HI = 15;
	localparam int W_OPC_LO = 8;
	localparam int W_RA_HI = 7;
	localparam int W_RA_LO = 4;
	localparam int W_RB_HI = 3;
	localparam int W_RB_LO = 0;
	localparam int W_TRAP_HI = 6;
	localparam int W_TRAP_LO = 0;
	localparam int W_CO_OP_HI = 7;
	localparam int W_CO_OP_LO = 4;
	localparam int W_CO_RND = 3;
	localparam int W_CO_UA = 2;
	localparam int W_CO_UB = 1;

	// Variant bit positions within the variant pair
	localparam int VAR_STEP2 = 0;
	localparam int VAR_POP = 0;

	typedef enum logic [4:0] {
		OP_ADD = 5'h00,
		OP_SUB = 5'h01,
		OP_MUL = 5'h02,
		OP_DIV = 5'h03,
		OP_LOGIC = 5'h04,
		OP_BITSET = 5'h05,
		OP_BITCOMB = 5'h06,
		OP_BFLD = 5'h07,
		OP_CMP = 5'h08,
		OP_CMPD = 5'h09,
		OP_CMPI = 5'h0a,
		OP_NORM = 5'h0b,
		OP_SHIFT = 5'h0c,
		OP_ARITH_SHIFT_RIGHT = 5'h0d,
		OP_MOV = 5'h0e,
		OP_MOVBX = 5'h0f,
		OP_JMP = 5'h10,
		OP_JBIT = 5'h11,
		OP_CALL = 5'h12,
		OP_PUSH_AND_CALL = 5'h13,
		OP_TRAP = 5'h14,
		OP_PUSHPOP = 5'h15,
		OP_CONTEXT_SWITCH_PUSH_LOAD = 5'h16,
		OP_RET = 5'h17,
		OP_SYS = 5'h18,
		OP_WDT = 5'h19,
		OP_EXTP = 5'h1a,
		OP_EXTS = 5'h1b,
		OP_ATOMIC = 5'h1c,
		OP_NOP = 5'h1d,
		OP_COPROC = 5'h1e,
		OP_ILLEGAL = 5'h1f
	} op_t;

	typedef enum logic [3:0] {
		CO_NOP = 4'h0,
		CO_MAC = 4'h1,
		CO_MACM = 4'h2,
		CO_ARITH_SHIFT_RIGHT = 4'h3,
		CO_MUL = 4'h4,
		CO_ADD = 4'h5,
		CO_SUB = 4'h6,
		CO_LOAD = 4'h7,
		CO_CMP = 4'h8,
		CO_ABS = 4'h9,
		CO_NEG = 4'ha,
		CO_RND = 4'hb,
		CO_SHL = 4'hc,
		CO_SHR = 4'hd,
		CO_MAXMIN = 4'he,
		CO_STORE = 4'hf
	} coop_t;

	typedef enum logic [1:0] {
		ST_FIRST = 2'b00,
		ST_SECOND = 2'b01,
		ST_BUSY = 2'b10
	} state_t;

	typedef enum logic [1:0] {
		LEN_SHORT = 2'b00,
		LEN_LONG = 2'b01,
		LEN_EITHER = 2'b10
	} lenkind_t;

	localparam logic [1:0] V_JBC = 2'h2;
	localparam logic [1:0] V_JUMP_AND_SET_BIT = 2'h3;
	localparam logic [1:0] V_RETURN_AND_POP = 2'h2;
	localparam logic [1:0] V_POWER_DOWN_ENTRY = 2'h2;
	localparam logic [1:0] V_END_OF_INIT = 2'h3;
	localparam logic [1:0] VAR_ZERO = 2'h0;

	localparam logic [2:0] LEN_BYTES_2 = 3'h2;
	localparam logic [2:0] LEN_BYTES_4 = 3'h4;

	localparam logic [3:0] CYC_SINGLE = 4'h1;
	localparam logic [3:0] CYC_BRANCH = 4'h2;
	localparam logic [3:0] CYC_MUL = 4'h5;
	localparam logic [3:0] CYC_DIV = 4'ha;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;

	localparam logic signed [2:0] STEP_NONE = 3'sh0;
	localparam logic signed [2:0] STEP_PLUS1 = 3'sh1;
	localparam logic signed [2:0] STEP_PLUS2 = 3'sh2;
	localparam logic signed [2:0] STEP_MINUS1 = 3'sh7;
	localparam logic signed [2:0] STEP_MINUS2 = 3'sh6;

	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [6:0] TRAP_ZERO = 7'h00;
	localparam logic [10:0] GPR_PAD = 11'h000;

	function automatic lenkind_t op_length(input op_t op);
		unique case (op)
			OP_ADD, OP_SUB, OP_LOGIC, OP_CMP, OP_CMPD, OP_CMPI, OP_MOV, OP_MOVBX,
			OP_EXTP, OP_EXTS: op_length = LEN_EITHER;
			OP_BITCOMB, OP_BFLD, OP_JMP, OP_JBIT, OP_CALL, OP_PUSH_AND_CALL, OP_CONTEXT_SWITCH_PUSH_LOAD,
			OP_SYS, OP_WDT, OP_COPROC: op_length = LEN_LONG;
			default: op_length = LEN_SHORT;
		endcase
	endfunction : op_length

	function automatic logic op_is_branch(input op_t op);
		op_is_branch = (op == OP_JMP) || (op == OP_JBIT) || (op == OP_CALL) ||
			(op == OP_PUSH_AND_CALL) || (op == OP_TRAP) || (op == OP_RET);
	endfunction : op_is_branch

	// Byte address of a word register in the active bank
	function automatic logic [15:0] gpr_addr(input logic [15:0] cp, input logic [3:0] n);
		gpr_addr = cp + {GPR_PAD, n, 1'b0};
	endfunction : gpr_addr

endpackage : isa_pkg

// [hw/op_classifier.sv]
`timescale 1ns/1ps
`default_nettype none
module op_classifier import isa_pkg::*; (
	dec_if.classify dec
);
	op_t op;
	lenkind_t kind;
	logic legal;

	always_comb begin
		op = op_t'(dec.opcode[OPC_BASE_HI:OPC_BASE_LO]);
		kind = op_length(op);
		legal = (op != OP_ILLEGAL) &&
			((kind == LEN_EITHER) || ((kind == LEN_LONG) == dec.opcode[OPC_LONG])); // see (RQ19)
		dec.baseOp = op;
		dec.variant = dec.opcode[OPC_VAR_HI:OPC_VAR_LO];
		dec.legal = legal;
		dec.len4 = legal && dec.opcode[OPC_LONG]; // see (RQ25)
		if (!legal) begin
			dec.cycles = CYC_SINGLE;
		end else if (op == OP_MUL) begin
			dec.cycles = CYC_MUL; // see (RQ23)
		end else if (op == OP_DIV) begin
			dec.cycles = CYC_DIV; // see (RQ23)
		end else if (op_is_branch(op)) begin
			dec.cycles = CYC_BRANCH; // see (RQ23)
		end else begin
			dec.cycles = CYC_SINGLE;
		end
	end

endmodule : op_classifier
`default_nettype wire

// [verif/fetch_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic slow,
	input wire logic fetchReady,
	output logic [15:0] fetchWord,
	output logic fetchValid
);
	logic [15:0] q[$];
	function automatic void push(input logic [15:0] w);
		q.push_back(w);
	endfunction : push
	// Holds each word until taken; idle bus shows a changing pattern
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fetchValid <= 1'b0;
			fetchWord <= 16'ha5a5;
		end else begin
			if (fetchValid && fetchReady) begin
				void'(q.pop_front());
			end
			if (q.size() != 0 && !(slow && fetchValid && fetchReady)) begin
				fetchValid <= 1'b1;
				fetchWord <= q[0];
			end else begin
				fetchValid <= 1'b0;
				fetchWord <= ~fetchWord;
			end
		end
	end
endmodule : fetch_model
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench import isa_pkg::*;;
	logic clk, arst_n, slow, nmiPin, fetchValid, fetchReady, decValid, illegal;
	logic [15:0] fetchWord, contextPointer, regAddrA, regAddrB, immWord;
	logic [2:0] lengthBytes;
	logic signed [2:0] regStep;
	op_t baseOp;
	coop_t coprocOp;
	logic [1:0] variant;
	logic [6:0] trapNumber;
	logic jumpClearBit, jumpSetBit, stackPush, stackPop, isCoproc, coprocRound;
	logic coprocUnsA, coprocUnsB, coprocMove, powerDown, resetOutActive, pd, ro;
	int err_total, n_tests;

	fetch_model i_fetch_model (.clk(clk), .arst_n(arst_n), .slow(slow),
		.fetchReady(fetchReady), .fetchWord(fetchWord), .fetchValid(fetchValid));

	cpu_mac_decoder i_cpu_mac_decoder (.clk(clk), .arst_n(arst_n), .fetchWord(fetchWord),
		.fetchValid(fetchValid), .fetchReady(fetchReady), .contextPointer(contextPointer),
		.nmiPin(nmiPin), .decValid(decValid), .lengthBytes(lengthBytes), .baseOp(baseOp),
		.variant(variant), .illegal(illegal), .regAddrA(regAddrA), .regAddrB(regAddrB),
		.immWord(immWord), .trapNumber(trapNumber), .regStep(regStep),
		.jumpClearBit(jumpClearBit), .jumpSetBit(jumpSetBit), .stackPush(stackPush),
		.stackPop(stackPop), .isCoproc(isCoproc), .coprocOp(coprocOp),
		.coprocRound(coprocRound), .coprocUnsA(coprocUnsA), .coprocUnsB(coprocUnsB),
		.coprocMove(coprocMove), .powerDown(powerDown), .resetOutActive(resetOutActive));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// Sends one instruction, then judges decode fields, stall and pulse width
	task automatic run(input op_t op, input logic [1:0] v, input logic lng,
		input logic [7:0] lo, input logic [15:0] imm);
		logic f2, f4, ill, brn, l4;
		logic [3:0] stall;
		logic signed [2:0] st;
		int n;
		f2 = op inside {OP_MUL, OP_DIV, OP_BITSET, OP_NORM, OP_SHIFT, OP_ARITH_SHIFT_RIGHT, OP_TRAP,
			OP_PUSHPOP, OP_RET, OP_ATOMIC, OP_NOP};
		f4 = op inside {OP_BITCOMB, OP_BFLD, OP_JMP, OP_JBIT, OP_CALL, OP_PUSH_AND_CALL, OP_CONTEXT_SWITCH_PUSH_LOAD,
			OP_SYS, OP_WDT, OP_COPROC};
		ill = op == OP_ILLEGAL || (f2 && lng) || (f4 && !lng);
		l4 = lng && !ill;
		brn = op inside {OP_JMP, OP_JBIT, OP_CALL, OP_PUSH_AND_CALL, OP_TRAP, OP_RET};
		stall = op == OP_MUL ? 4'h4 : op == OP_DIV ? 4'h9 : brn ? 4'h1 : 4'h0;
		st = op == OP_CMPI ? (v[0] ? STEP_PLUS2 : STEP_PLUS1) :
			op == OP_CMPD ? (v[0] ? STEP_MINUS2 : STEP_MINUS1) : STEP_NONE;
		if (!ill && op == OP_SYS && v == V_POWER_DOWN_ENTRY && !nmiPin) pd = 1'b1;
		if (!ill && op == OP_SYS && v == V_END_OF_INIT) ro = 1'b0;
		@(negedge clk);
		i_fetch_model.push({op, v, lng, lo});
		if (l4) i_fetch_model.push(imm);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (decValid !== 1'b1 && n < 40);
		if (n >= 40) begin
			err_total++;
			report_and_stop();
		end
		chk(16'(illegal), 16'(ill), "illegal");
		chk(16'(lengthBytes), l4 ? 16'h4 : 16'h2, "length");
		if (!ill) begin
			chk(16'(baseOp), 16'(op), "op");
			chk(16'(variant), 16'(v), "variant");
			chk(immWord, l4 ? imm : 16'h0, "imm");
			chk(16'(regStep), 16'(st), "step");
			chk(16'(trapNumber), op == OP_TRAP ? 16'(lo[6:0]) : 16'h0, "trap");
			chk(16'(jumpClearBit), 16'(op == OP_JBIT && v == V_JBC), "jbc");
			chk(16'(jumpSetBit), 16'(op == OP_JBIT && v == V_JUMP_AND_SET_BIT), "jbs");
			chk(16'(stackPush), 16'(op inside {OP_PUSH_AND_CALL, OP_CONTEXT_SWITCH_PUSH_LOAD} ||
				(op == OP_PUSHPOP && !v[0])), "push");
			chk(16'(stackPop), 16'((op == OP_RET && v == V_RETURN_AND_POP) ||
				(op == OP_PUSHPOP && v[0])), "pop");
			chk(16'(isCoproc), 16'(op == OP_COPROC), "coproc");
			if (op == OP_COPROC) begin
				chk(16'(coprocOp), 16'(lo[7:4]), "co op");
				chk(16'(coprocRound), 16'(lo[3]), "round");
				chk(16'({coprocUnsA, coprocUnsB}), 16'(lo[2:1]), "sign");
				chk(16'(coprocMove), 16'(lo[7:4] == CO_MACM), "move");
			end else if (op != OP_TRAP) begin
				chk(regAddrA, contextPointer + {lo[7:4], 1'b0}, "reg a");
				chk(regAddrB, contextPointer + {lo[3:0], 1'b0}, "reg b");
			end
		end
		chk(16'(powerDown), 16'(pd), "power down");
		chk(16'(resetOutActive), 16'(ro), "reset out");
		n = 0;
		while (fetchReady === 1'b0 && n < 12) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 12) begin
			err_total++;
			report_and_stop();
		end
		if (!ill) chk(16'(n), 16'(stall), "stall");
		if (n == 0) begin
			@(posedge clk);
			#1;
		end
		chk(16'(decValid), 16'h0, "pulse");
	endtask : run

	task automatic sc_reset();
		#1;
		chk(16'(fetchReady), 16'h1, "ready");
		chk(16'(lengthBytes), 16'h2, "length");
		chk(16'(resetOutActive), 16'h1, "reset out");
		chk(16'(powerDown), 16'h0, "power down");
		@(posedge clk);
		arst_n <= 1'b1;
	endtask : sc_reset

	task automatic sc_arith();
		for (int i = 0; i < 4; i++) begin
			run(OP_ADD, 2'(i), i[0], 8'h1f, 16'hc3a5);
			run(OP_SUB, 2'(i), ~i[0], 8'hf1, 16'h5a3c);
			run(OP_MUL, 2'(i), 1'b0, 8'h9e, 16'h0);
			run(OP_DIV, 2'(i), 1'b0, 8'he9, 16'h0);
			run(OP_LOGIC, 2'(i), i[1], 8'h3c, 16'h0f0f);
		end
	endtask : sc_arith

	task automatic sc_bits();
		for (int i = 0; i < 4; i++) begin
			run(OP_BITSET, 2'(i), 1'b0, 8'h47, 16'h0);
			run(OP_BITCOMB, 2'(i), 1'b1, 8'h74, 16'h8001);
			run(OP_BFLD, 2'(i), 1'b1, 8'hd2, 16'hf00f);
			run(OP_MOVBX, 2'(i), i[1], 8'h2d, 16'h7ffe);
			run(OP_SHIFT, 2'(i), 1'b0, 8'h65, 16'h0);
		end
		run(OP_NORM, 2'h0, 1'b0, 8'hf0, 16'h0);
		run(OP_ARITH_SHIFT_RIGHT, 2'h1, 1'b0, 8'h0f, 16'h0);
	endtask : sc_bits

	task automatic sc_steps();
		@(posedge clk);
		contextPointer <= 16'hfde0;
		for (int i = 0; i < 4; i++) begin
			run(OP_CMPD, 2'(i), i[1], 8'hf7, 16'h1234);
			run(OP_CMPI, 2'(i), ~i[1], 8'h7f, 16'h4321);
			run(OP_MOV, 2'(i), i[0], 8'hff, 16'hffff);
			run(OP_CMP, 2'(i), ~i[0], 8'h5b, 16'hbeef);
		end
	endtask : sc_steps

	task automatic sc_flow();
		@(posedge clk);
		slow <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			run(OP_JBIT, 2'(i), 1'b1, 8'h5a, 16'h00fe);
			run(OP_RET, 2'(i), 1'b0, 8'ha5, 16'h0);
			run(OP_PUSHPOP, 2'(i), 1'b0, 8'h3e, 16'h0);
			run(OP_EXTP, 2'(i), i[0], 8'h81, 16'h03ff);
			run(OP_EXTS, 2'(i), ~i[0], 8'h18, 16'h00ff);
		end
		run(OP_PUSH_AND_CALL, 2'h0, 1'b1, 8'hc1, 16'h8000);
		run(OP_CONTEXT_SWITCH_PUSH_LOAD, 2'h1, 1'b1, 8'h1c, 16'h5555);
		run(OP_TRAP, 2'h3, 1'b0, 8'h7f, 16'h0);
		run(OP_TRAP, 2'h0, 1'b0, 8'h80, 16'h0);
		run(OP_JMP, 2'h0, 1'b1, 8'h00, 16'h0100);
		@(posedge clk);
		slow <= 1'b0;
	endtask : sc_flow

	task automatic sc_coproc();
		for (int i = 0; i < 16; i++) begin
			run(OP_COPROC, 2'(i), 1'b1, {4'(i), 4'(15 - i)}, 16'(i * 4369));
		end
		run(OP_COPROC, 2'h0, 1'b0, 8'h1e, 16'h0);
	endtask : sc_coproc

	task automatic sc_illegal();
		run(OP_ILLEGAL, 2'h3, 1'b1, 8'h11, 16'h0);
		run(OP_MUL, 2'h0, 1'b1, 8'h22, 16'h0);
		run(OP_BFLD, 2'h1, 1'b0, 8'h33, 16'h0);
		run(OP_NOP, 2'h0, 1'b0, 8'h00, 16'h0);
		run(OP_ATOMIC, 2'h2, 1'b0, 8'h6c, 16'h0);
	endtask : sc_illegal

	task automatic sc_sys();
		run(OP_SYS, V_POWER_DOWN_ENTRY, 1'b1, 8'h00, 16'h0);
		run(OP_SYS, 2'h0, 1'b1, 8'h00, 16'h0);
		run(OP_WDT, 2'h1, 1'b1, 8'h00, 16'h0);
		@(posedge clk);
		nmiPin <= 1'b0;
		repeat (3) @(posedge clk);
		run(OP_SYS, V_END_OF_INIT, 1'b0, 8'h11, 16'h0);
		run(OP_SYS, V_END_OF_INIT, 1'b1, 8'h11, 16'h2222);
		run(OP_SYS, V_POWER_DOWN_ENTRY, 1'b1, 8'h00, 16'h0);
		@(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		#1;
		chk(16'({powerDown, resetOutActive}), 16'h1, "second reset");
		pd = 1'b0;
		ro = 1'b1;
		@(posedge clk);
		arst_n <= 1'b1;
		nmiPin <= 1'b1;
	endtask : sc_sys

	initial begin
		arst_n = 1'b0;
		slow = 1'b0;
		nmiPin = 1'b1;
		contextPointer = 16'h0040;
		err_total = 0;
		n_tests = 0;
		pd = 1'b0;
		ro = 1'b1;
		repeat (15) @(posedge clk);
		sc_reset();
		sc_arith();
		sc_bits();
		sc_steps();
		sc_flow();
		sc_coproc();
		sc_illegal();
		sc_sys();
		run(OP_ADD, 2'h0, 1'b0, 8'h12, 16'h0);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
